// ### shared/rbml_pkg.sv
// Shared types and reset values for the reset and boot-mode latch
package rbml_pkg;

   localparam int RBML_MODE_W = 3;
   localparam int RBML_NUM_MODES = 8;
   localparam int RBML_SYNC_W = 2;

   typedef enum logic [1:0] {
      RBML_ST_RESET,
      RBML_ST_BOOT,
      RBML_ST_RUN
   } rbml_state_e;

   typedef struct packed {
      logic [RBML_SYNC_W-1:0] rst_sync;
      logic lvd_meta;
      logic lvd_sync;
      logic [RBML_MODE_W-1:0] pin_meta;
      logic [RBML_MODE_W-1:0] pin_sync;
      rbml_state_e state;
      logic [RBML_MODE_W-1:0] boot_mode;
      logic [RBML_NUM_MODES-1:0] mode_sel;
      logic rst_ind;
      logic core_rst_n;
      logic boot_active;
      logic released;
      logic [RBML_MODE_W-1:0] pin_o;
      logic [RBML_MODE_W-1:0] pin_oe;
      logic [RBML_MODE_W-1:0] gpio_in;
   } rbml_state_s;

   localparam logic [RBML_SYNC_W-1:0] RBML_RST_SYNC_RST = 2'h0;
   localparam logic [RBML_MODE_W-1:0] RBML_PIN_RST = 3'h0;
   localparam logic [RBML_MODE_W-1:0] RBML_BOOT_MODE_RST = 3'h0;
   localparam logic [RBML_NUM_MODES-1:0] RBML_MODE_SEL_RST = 8'h01;
   localparam logic RBML_RST_IND_RST = 1'h1;

endpackage

// ### rtl/rbml_reset_boot.sv
// Reset entry, reset indicator and boot-mode strap capture with port H hand-back
// Function
// (R1) While external reset pin is low, device is initialised and held in reset.
// (R2) On reset pin release, capture the three mode pins as the operating mode.
// (R3) The captured three-bit mode selects exactly one of eight bootstrap modes.
// (R4) After bootstrap completes, mode pins become general-purpose port H pins.
// (R5) Reset output asserted for pin, low-voltage, software or watchdog reset.
// (R6) Board should assert reset and test reset together for a full reset.
// (R7) To keep debug state, board asserts reset only, test reset stays released.
// (R8) Reset release is synchronised to the system clock before mode capture.
`timescale 1ns/100ps

module rbml_reset_boot (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_lvd_reset,
   input wire logic i_sw_reset,
   input wire logic i_watchdog_timeout,
   input wire logic i_boot_done,
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_port_h_pin_i,
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_gpio_out,
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_gpio_oe,
   output logic [rbml_pkg::RBML_MODE_W-1:0] o_port_h_pin_o,
   output logic [rbml_pkg::RBML_MODE_W-1:0] o_port_h_pin_oe,
   output logic [rbml_pkg::RBML_MODE_W-1:0] o_gpio_in,
   output logic o_reset_indicator_out,
   output logic o_core_reset_n,
   output logic o_bootstrap_active,
   output logic o_gpio_released,
   output logic [rbml_pkg::RBML_MODE_W-1:0] o_boot_mode,
   output logic [rbml_pkg::RBML_NUM_MODES-1:0] o_boot_mode_sel
);
   import rbml_pkg::*;

   rbml_state_s st_reg;
   rbml_state_s st_next;
   logic any_src;

   function automatic logic [RBML_NUM_MODES-1:0] rbml_onehot(
      input logic [RBML_MODE_W-1:0] mode
   );
      logic [RBML_NUM_MODES-1:0] sel;
      sel = '0;
      sel[mode] = 1'b1;
      return sel;
   endfunction

   // Internal sources are same-clock except low-voltage, which is synchronised
   assign any_src = !st_reg.rst_sync[RBML_SYNC_W-1] || st_reg.lvd_sync
                    || i_sw_reset || i_watchdog_timeout;

   always_comb begin
      st_next = st_reg;
      // Async assert, clocked release: shifts ones in after the pin goes high
      st_next.rst_sync = {st_reg.rst_sync[RBML_SYNC_W-2:0], 1'b1}; // see (R8)
      st_next.lvd_meta = i_lvd_reset;
      st_next.lvd_sync = st_reg.lvd_meta;
      st_next.pin_meta = i_port_h_pin_i;
      st_next.pin_sync = st_reg.pin_meta;
      st_next.rst_ind = any_src; // see (R5)
      unique case (st_reg.state)
         RBML_ST_RESET: begin
            if (!any_src) begin
               // Straps sampled only after the synchronised release
               st_next.boot_mode = st_reg.pin_sync; // see (R2) (R8)
               st_next.mode_sel = rbml_onehot(st_reg.pin_sync); // see (R3)
               st_next.state = RBML_ST_BOOT;
            end
         end
         RBML_ST_BOOT: begin
            if (i_boot_done) begin
               st_next.state = RBML_ST_RUN;
            end
         end
         RBML_ST_RUN: begin
            st_next.state = RBML_ST_RUN;
         end
      endcase
      // Any source pulls the device back; the straps are read again on exit
      if (any_src) begin
         st_next.state = RBML_ST_RESET; // see (R1)
      end
      st_next.core_rst_n = (st_next.state != RBML_ST_RESET); // see (R1)
      st_next.boot_active = (st_next.state == RBML_ST_BOOT);
      st_next.released = (st_next.state == RBML_ST_RUN);
      // Pins stay undriven until the port takes them over
      if (st_next.state == RBML_ST_RUN) begin
         st_next.pin_o = i_gpio_out; // see (R4)
         st_next.pin_oe = i_gpio_oe; // see (R4)
         st_next.gpio_in = st_reg.pin_sync;
      end else begin
         st_next.pin_o = RBML_PIN_RST;
         st_next.pin_oe = RBML_PIN_RST;
         st_next.gpio_in = RBML_PIN_RST;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg.rst_sync <= RBML_RST_SYNC_RST; // see (R1)
         st_reg.lvd_meta <= 1'b0;
         st_reg.lvd_sync <= 1'b0;
         st_reg.pin_meta <= RBML_PIN_RST;
         st_reg.pin_sync <= RBML_PIN_RST;
         st_reg.state <= RBML_ST_RESET;
         st_reg.boot_mode <= RBML_BOOT_MODE_RST;
         st_reg.mode_sel <= RBML_MODE_SEL_RST;
         st_reg.rst_ind <= RBML_RST_IND_RST; // see (R5)
         st_reg.core_rst_n <= 1'b0;
         st_reg.boot_active <= 1'b0;
         st_reg.released <= 1'b0;
         st_reg.pin_o <= RBML_PIN_RST;
         st_reg.pin_oe <= RBML_PIN_RST;
         st_reg.gpio_in <= RBML_PIN_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_port_h_pin_o = st_reg.pin_o;
   assign o_port_h_pin_oe = st_reg.pin_oe;
   assign o_gpio_in = st_reg.gpio_in;
   assign o_reset_indicator_out = st_reg.rst_ind;
   assign o_core_reset_n = st_reg.core_rst_n;
   assign o_bootstrap_active = st_reg.boot_active;
   assign o_gpio_released = st_reg.released;
   assign o_boot_mode = st_reg.boot_mode;
   assign o_boot_mode_sel = st_reg.mode_sel;

   property p_hold_in_reset;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !st_reg.rst_sync[RBML_SYNC_W-1] |=> !o_core_reset_n && !o_gpio_released;
   endproperty
   a_hold_in_reset: assert property (p_hold_in_reset) // see (R1)
      else $error("core left reset before synchronised release");

   property p_capture;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (st_reg.state == RBML_ST_RESET && !any_src)
         |=> o_boot_mode == $past(st_reg.pin_sync) && o_bootstrap_active;
   endproperty
   a_capture: assert property (p_capture) // see (R2)
      else $error("boot mode not captured from straps on release");

   property p_one_of_eight;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      o_core_reset_n |-> $onehot(o_boot_mode_sel) && o_boot_mode_sel[o_boot_mode];
   endproperty
   a_one_of_eight: assert property (p_one_of_eight) // see (R3)
      else $error("boot mode select is not the one-hot of the mode");

   property p_pins_held;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !o_gpio_released |-> o_port_h_pin_oe == 3'h0 && o_gpio_in == 3'h0;
   endproperty
   a_pins_held: assert property (p_pins_held) // see (R4)
      else $error("port H driven before bootstrap completed");

   property p_pins_handed;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (st_reg.state == RBML_ST_BOOT && i_boot_done && !any_src)
         ##1 (!any_src) [*2] |=> o_gpio_released && o_port_h_pin_oe == $past(i_gpio_oe);
   endproperty
   a_pins_handed: assert property (p_pins_handed) // see (R4)
      else $error("port H not handed over after bootstrap");

   property p_rst_ind;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_sw_reset || i_watchdog_timeout || st_reg.lvd_sync)
         |=> o_reset_indicator_out && !o_core_reset_n && !o_gpio_released;
   endproperty
   a_rst_ind: assert property (p_rst_ind) // see (R5)
      else $error("reset output missed an internal reset source");

   property p_sync_release;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_core_reset_n) |-> $past(st_reg.rst_sync[RBML_SYNC_W-1])
         && !o_reset_indicator_out;
   endproperty
   a_sync_release: assert property (p_sync_release) // see (R8)
      else $error("core released without synchronised reset release");

   // A late strap change must never leak into the mode between captures
   property p_mode_held;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !(st_reg.state == RBML_ST_RESET && !any_src) |=> $stable(o_boot_mode);
   endproperty
   a_mode_held: assert property (p_mode_held) // see (R2)
      else $error("boot mode changed outside a strap capture");

   property p_pins_follow;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (st_reg.state == RBML_ST_RUN && !any_src)
         |=> o_port_h_pin_o == $past(i_gpio_out) && o_port_h_pin_oe == $past(i_gpio_oe);
   endproperty
   a_pins_follow: assert property (p_pins_follow) // see (R4)
      else $error("port H output does not follow the port logic");

   property p_gpio_in;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (st_reg.state == RBML_ST_RUN && !any_src) |=> o_gpio_in == $past(st_reg.pin_sync);
   endproperty
   a_gpio_in: assert property (p_gpio_in) // see (R4)
      else $error("port H input levels not passed to the port logic");

   property p_ind_clear;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !any_src |=> !o_reset_indicator_out && o_core_reset_n;
   endproperty
   a_ind_clear: assert property (p_ind_clear) // see (R5)
      else $error("reset output held with no reset source active");

   property p_quiet_in_reset;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !o_core_reset_n |-> o_port_h_pin_o == RBML_PIN_RST && !o_bootstrap_active;
   endproperty
   a_quiet_in_reset: assert property (p_quiet_in_reset) // see (R1)
      else $error("device active while held in reset");

   c_mode_seven: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_bootstrap_active) && o_boot_mode == 3'h7);
   c_reach_run: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_gpio_released));
   c_wdt_from_run: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_gpio_released && i_watchdog_timeout ##1 o_reset_indicator_out);
   c_lvd_source: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
      st_reg.lvd_sync ##1 o_reset_indicator_out);

endmodule

// ### sim/rbml_board.sv
// Board model: strap resistors and pad resolution for port H
`timescale 1ns/100ps
module rbml_board (
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_pin_o,
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_pin_oe,
   input wire logic [rbml_pkg::RBML_MODE_W-1:0] i_strap,
   output logic [rbml_pkg::RBML_MODE_W-1:0] o_pad
);
   import rbml_pkg::*;
   // Undriven pads settle to the strap resistor level, never to the last driven value
   // Test reset is not modelled; the bench pulses only the block reset
   always_comb begin
      for (int b = 0; b < RBML_MODE_W; b++) begin
         o_pad[b] = i_pin_oe[b] ? i_pin_o[b] : i_strap[b];
      end
   end
endmodule

// ### sim/tb.sv
// Self-checking bench for the reset and boot-mode latch
`timescale 1ns/100ps
module tb;
   import rbml_pkg::*;
   logic clk, rstn, lvd, sw, wdt, done, ind, crn, ba, rel, ba_d;
   logic [2:0] strap, gout, goe, pad, po, poe, gin, mode;
   logic [7:0] sel;
   logic [31:0] seed;
   logic [2:0] q[$];
   int miscompares, checked;
   rbml_reset_boot dut(.i_sys_clk(clk), .i_resetn(rstn), .i_lvd_reset(lvd),
      .i_sw_reset(sw), .i_watchdog_timeout(wdt), .i_boot_done(done),
      .i_port_h_pin_i(pad), .i_gpio_out(gout), .i_gpio_oe(goe),
      .o_port_h_pin_o(po), .o_port_h_pin_oe(poe), .o_gpio_in(gin),
      .o_reset_indicator_out(ind), .o_core_reset_n(crn), .o_bootstrap_active(ba),
      .o_gpio_released(rel), .o_boot_mode(mode), .o_boot_mode_sel(sel));
   rbml_board board(.i_pin_o(po), .i_pin_oe(poe), .i_strap(strap), .o_pad(pad));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic final_report;
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait for capture; a hang ends the run
   task automatic wait_ba;
      int k;
      for (k = 0; k < 20 && ba !== 1'b1; k++) cyc(1);
      if (ba !== 1'b1) begin
         miscompares++;
         final_report();
      end
   endtask
   // Pull the reset pin for two cycles and expect the strap value back
   task automatic reset_with(input logic [2:0] m);
      strap = m;
      rstn = 1'b0; // Block reset only, test reset stays released
      cyc(2);
      chk("ind", 8'h01, 8'(ind));
      chk("core", 8'h00, 8'(crn));
      chk("oe", 8'h00, 8'(poe));
      q.push_back(m);
      rstn = 1'b1;
      wait_ba();
      strap = ~m; // Late strap change must not alter the mode
      cyc(3);
      chk("held", 8'(m), 8'(mode));
   endtask
   // Capture monitor: pop the oldest expected mode on each entry to bootstrap
   always @(negedge clk) begin
      if (ba === 1'b1 && ba_d !== 1'b1) begin
         chk("qsize", 8'h01, 8'(q.size() > 0));
         if (q.size() > 0) begin
            chk("mode", 8'(q[0]), 8'(mode));
            chk("sel", 8'h01 << q[0], sel);
            chk("ind", 8'h00, 8'(ind));
            void'(q.pop_front());
         end
      end
      ba_d <= ba;
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {rstn, lvd, sw, wdt, done} = 5'h00; // Power-on reset, block reset only
      {strap, gout, goe} = 9'h000;
      seed = 32'hD1066750;
      cyc(2);
      for (int m = 0; m < 8; m++) reset_with(3'(m));
      seed = xs(seed);
      {gout, goe} = seed[5:0];
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      chk("rel", 8'h01, 8'(rel));
      chk("po", 8'(gout), 8'(po));
      chk("poe", 8'(goe), 8'(poe));
      cyc(4);
      chk("gin", 8'((gout & goe) | (strap & ~goe)), 8'(gin));
      for (int s = 0; s < 3; s++) begin
         // Each source is raised from the run state, so the pins are taken back
         done = 1'b1;
         cyc(1);
         done = 1'b0;
         chk("rel", 8'h01, 8'(rel));
         seed = xs(seed);
         strap = seed[2:0];
         {wdt, sw, lvd} = 3'h1 << s;
         cyc(3);
         chk("ind", 8'h01, 8'(ind));
         chk("core", 8'h00, 8'(crn));
         chk("rel", 8'h00, 8'(rel));
         q.push_back(strap);
         {wdt, sw, lvd} = 3'h0;
         wait_ba();
      end
      cyc(2);
      final_report();
   end
endmodule
